/* File: nps_oc_stages.sv */
// Four-stage negative sequence overcurrent element with AXI4-Lite settings
// Overview of operation
// - Four independent stages, each with own pickup and delay timer.
// - Trip only after stage stays started for its configured delay.
// - Each stage non-directional, forward-only or reverse-only.
// - Direction from I2 angle versus char angle, centred on inverted V2.
// - Directional stage operates only while V2 exceeds polarizing threshold.
// - VT supervision: option 1 blocks directional stage, 0 reverts non-directional.
// - One inhibit input blocks all four stages.
// - Per-stage timer block prevents that stage tripping.
// - Per-stage start output high while stage started.
// - Per-stage trip output high once stage tripped.
// - Trips combined into auto-reclose block output.
// - Starts combined into common any-start output.
// - Inhibit, timer block, start and trip exposed as scheme logic signals.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns

module nps_oc_stages #(
   parameter int TICK_CYCLES = nps_oc_pkg::TICK_CYCLES,
   parameter int STAGES = nps_oc_pkg::STAGES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Measurements
   input nps_oc_pkg::meas_t meas,
   // Scheme logic inputs
   input wire logic vt_supervision,
   input wire logic all_stage_inhibit,
   input wire logic [STAGES-1:0] stage_timer_block,
   // Scheme logic outputs
   output logic [STAGES-1:0] stage_start_out,
   output logic [STAGES-1:0] stage_trip_out,
   output logic any_start_out,
   output logic ar_block_out,
   // AXI4-Lite write address
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [nps_oc_pkg::ADDR_W-1:0] s_awaddr,
   input wire logic [2:0] s_awprot,
   // AXI4-Lite write data
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   // AXI4-Lite write response
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   // AXI4-Lite read address
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [nps_oc_pkg::ADDR_W-1:0] s_araddr,
   input wire logic [2:0] s_arprot,
   // AXI4-Lite read data
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp
);

   // ********************************************
   // Functions
   // ********************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         res[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
      end
      return res;
   endfunction
   function automatic logic mapped(input logic [nps_oc_pkg::ADDR_W-1:0] addr);
      return addr < nps_oc_pkg::OFF_END;
   endfunction
   // ********************************************
   // Register storage
   // ********************************************
   logic [15:0] ctrl_reg;
   logic [15:0] pol_thresh_reg;
   logic [8:0] char_angle_reg;
   logic [15:0] pickup_reg [STAGES];
   logic [15:0] delay_reg [STAGES];

   // ********************************************
   // AXI4-Lite write path
   // ********************************************
   logic aw_have_reg;
   logic w_have_reg;
   logic [nps_oc_pkg::ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   wire aw_take = s_awvalid & s_awready;
   wire w_take = s_wvalid & s_wready;
   wire do_write = aw_have_reg & w_have_reg & ~s_bvalid;
   wire [3:0] w_index = aw_addr_reg[5:2];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (aw_take) begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_awaddr;
      end else if (do_write) begin
         aw_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         w_have_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (w_take) begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_wdata;
         w_strb_reg <= s_wstrb;
      end else if (do_write) begin
         w_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_awready <= 1'b0;
         s_wready <= 1'b0;
      end else begin
         s_awready <= ~(aw_take | (aw_have_reg & ~do_write));
         s_wready <= ~(w_take | (w_have_reg & ~do_write));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_bvalid <= 1'b0;
         s_bresp <= nps_oc_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_bvalid <= 1'b1;
         s_bresp <= mapped(aw_addr_reg) ? nps_oc_pkg::RESP_OKAY : nps_oc_pkg::RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // ********************************************
   // Settings registers
   // ********************************************
   wire wr_ctrl = do_write && aw_addr_reg == nps_oc_pkg::OFF_CTRL;
   wire wr_pol = do_write && aw_addr_reg == nps_oc_pkg::OFF_POL_THRESH;
   wire wr_ang = do_write && aw_addr_reg == nps_oc_pkg::OFF_CHAR_ANGLE;
   wire [31:0] ctrl_new = merge({16'h0000, ctrl_reg}, w_data_reg, w_strb_reg);
   wire [31:0] pol_new = merge({16'h0000, pol_thresh_reg}, w_data_reg, w_strb_reg);
   wire [31:0] ang_new = merge({23'h000000, char_angle_reg}, w_data_reg, w_strb_reg);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_reg <= nps_oc_pkg::RST_CTRL;
         pol_thresh_reg <= nps_oc_pkg::RST_POL_THRESH;
         char_angle_reg <= nps_oc_pkg::RST_CHAR_ANGLE;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= ctrl_new[15:0];
         end
         if (wr_pol) begin
            pol_thresh_reg <= pol_new[15:0];
         end
         if (wr_ang) begin
            char_angle_reg <= ang_new[8:0];
         end
      end
   end

   // ********************************************
   // Measurement tick for the delay timers
   // ********************************************
   logic [31:0] div_reg;
   logic tick_reg;
   wire div_wrap = div_reg == 32'(TICK_CYCLES - 1);
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= div_wrap ? 32'h00000000 : div_reg + 32'h00000001;
         tick_reg <= div_wrap;
      end
   end

   // ********************************************
   // Direction, common to all stages
   // ********************************************
   // I2 angle taken against -V2, then offset by the characteristic angle
   wire [10:0] rot_raw = {2'b00, meas.i2_v2_angle} + nps_oc_pkg::ANG_INV_BIAS
                         - {2'b00, char_angle_reg};
   wire [10:0] rot = (rot_raw >= nps_oc_pkg::ANG_TWO_FULL) ? rot_raw - nps_oc_pkg::ANG_TWO_FULL :
                     (rot_raw >= nps_oc_pkg::ANG_FULL) ? rot_raw - nps_oc_pkg::ANG_FULL : rot_raw;
   wire is_fwd = rot < nps_oc_pkg::ANG_QUARTER || rot > nps_oc_pkg::ANG_THREE_Q;
   wire is_rev = rot > nps_oc_pkg::ANG_QUARTER && rot < nps_oc_pkg::ANG_THREE_Q;
   wire pol_ok = meas.v2_mag > pol_thresh_reg;

   // ********************************************
   // Stages
   // ********************************************
   logic [STAGES-1:0] start_now;
   logic [STAGES-1:0] trip_now;
   generate
      for (genvar s = 0; s < STAGES; s++) begin : g_stage
         logic [16:0] timer_reg;
         nps_oc_pkg::stage_cfg_t cfg;
         assign cfg = ctrl_reg[s*nps_oc_pkg::CTRL_NIB_W +: nps_oc_pkg::CTRL_NIB_W];
         // Unused fourth mode code behaves as non-directional
         wire directional = cfg.dir_mode inside {nps_oc_pkg::DIR_FWD, nps_oc_pkg::DIR_REV};
         wire vt_blocked = directional & vt_supervision & cfg.vt_block_opt;
         wire vt_revert = directional & vt_supervision & ~cfg.vt_block_opt;
         wire dir_hit = (cfg.dir_mode == nps_oc_pkg::DIR_FWD) ? is_fwd : is_rev;
         wire dir_ok = ~directional | vt_revert | (pol_ok & dir_hit);
         wire over = meas.i2_mag > pickup_reg[s];
         // Inhibit or VT blocking drops start, which also resets the timer; the timer block gates trip only
         assign start_now[s] = cfg.enable & ~all_stage_inhibit & ~vt_blocked
                               & over & dir_ok;
         // The first tick after start may come at once, so a delay of D needs D+1 counts
         assign trip_now[s] = start_now[s] & ~stage_timer_block[s] & (delay_reg[s] == 16'h0000
                              || timer_reg > {1'b0, delay_reg[s]});
         always_ff @(posedge clk) begin
            if (!rst_b || !start_now[s]) begin
               timer_reg <= '0;
            end else if (tick_reg && timer_reg != 17'h1ffff) begin
               timer_reg <= timer_reg + 17'h00001;
            end
         end
         wire [31:0] pick_new = merge({16'h0000, pickup_reg[s]}, w_data_reg, w_strb_reg);
         wire [31:0] dly_new = merge({16'h0000, delay_reg[s]}, w_data_reg, w_strb_reg);
         wire wr_pick = do_write && w_index == 4'(4 + s) && aw_addr_reg[7:6] == 2'b00;
         wire wr_dly = do_write && w_index == 4'(8 + s) && aw_addr_reg[7:6] == 2'b00;
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               pickup_reg[s] <= nps_oc_pkg::RST_PICKUP;
               delay_reg[s] <= nps_oc_pkg::RST_DELAY;
            end else begin
               if (wr_pick) begin
                  pickup_reg[s] <= pick_new[15:0];
               end
               if (wr_dly) begin
                  delay_reg[s] <= dly_new[15:0];
               end
            end
         end
      end
   endgenerate

   // ********************************************
   // Scheme logic outputs
   // ********************************************
   logic fwd_reg;
   logic rev_reg;
   logic pol_reg;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stage_start_out <= '0;
         stage_trip_out <= '0;
         any_start_out <= 1'b0;
         ar_block_out <= 1'b0;
         fwd_reg <= 1'b0;
         rev_reg <= 1'b0;
         pol_reg <= 1'b0;
      end else begin
         stage_start_out <= start_now;
         stage_trip_out <= trip_now;
         any_start_out <= |start_now;
         ar_block_out <= |trip_now;
         fwd_reg <= is_fwd;
         rev_reg <= is_rev;
         pol_reg <= pol_ok;
      end
   end

   // ********************************************
   // AXI4-Lite read path
   // ********************************************
   wire ar_take = s_arvalid & s_arready;
   wire [3:0] r_index = s_araddr[5:2];
   wire [1:0] r_sub = r_index[1:0];
   logic [31:0] status_word;
   logic [31:0] read_mux;

   always_comb begin
      status_word = '0;
      status_word[nps_oc_pkg::ST_START_LSB +: STAGES] = stage_start_out;
      status_word[nps_oc_pkg::ST_TRIP_LSB +: STAGES] = stage_trip_out;
      status_word[nps_oc_pkg::ST_FWD_BIT] = fwd_reg;
      status_word[nps_oc_pkg::ST_REV_BIT] = rev_reg;
      status_word[nps_oc_pkg::ST_POL_BIT] = pol_reg;
   end

   always_comb begin
      if (!mapped(s_araddr)) begin
         read_mux = '0;
      end else if (s_araddr >= nps_oc_pkg::OFF_DELAY0) begin
         read_mux = {16'h0000, delay_reg[r_sub]};
      end else if (s_araddr >= nps_oc_pkg::OFF_PICKUP0) begin
         read_mux = {16'h0000, pickup_reg[r_sub]};
      end else begin
         case (r_sub)
            2'h0: read_mux = {16'h0000, ctrl_reg};
            2'h1: read_mux = {16'h0000, pol_thresh_reg};
            2'h2: read_mux = {23'h000000, char_angle_reg};
            2'h3: read_mux = status_word;
            default: read_mux = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_arready <= 1'b0;
      end else begin
         s_arready <= ~(ar_take | (s_rvalid & ~s_rready));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_rvalid <= 1'b0;
         s_rdata <= '0;
         s_rresp <= nps_oc_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_rvalid <= 1'b1;
         s_rdata <= read_mux;
         s_rresp <= mapped(s_araddr) ? nps_oc_pkg::RESP_OKAY : nps_oc_pkg::RESP_SLVERR;
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

endmodule

/* File: nps_oc_pkg.sv */
// Package for the negative sequence overcurrent stages: map, fields, types and timing
package nps_oc_pkg;

   // ********************************************
   // Sizes
   // ********************************************
   localparam int STAGES = 4;
   localparam int MAG_W = 16;
   localparam int ANG_W = 9;
   localparam int ADDR_W = 8;

   // ********************************************
   // Register byte offsets
   // ********************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_POL_THRESH = 8'h04;
   localparam logic [7:0] OFF_CHAR_ANGLE = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_PICKUP0 = 8'h10;
   localparam logic [7:0] OFF_DELAY0 = 8'h20;
   localparam logic [7:0] OFF_END = 8'h30;

   // ********************************************
   // Control field layout, one nibble per stage
   // ********************************************
   localparam int CTRL_NIB_W = 4;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DIR_LSB = 1;
   localparam int CTRL_VT_BLOCK_BIT = 3;

   // ********************************************
   // Status field layout
   // ********************************************
   localparam int ST_START_LSB = 0;
   localparam int ST_TRIP_LSB = 4;
   localparam int ST_FWD_BIT = 8;
   localparam int ST_REV_BIT = 9;
   localparam int ST_POL_BIT = 10;

   // ********************************************
   // Reset values
   // ********************************************
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] RST_POL_THRESH = 16'h0000;
   localparam logic [8:0] RST_CHAR_ANGLE = 9'h000;
   localparam logic [15:0] RST_PICKUP = 16'hffff;
   localparam logic [15:0] RST_DELAY = 16'h0000;

   // ********************************************
   // Angles in degrees
   // ********************************************
   localparam logic [10:0] ANG_QUARTER = 11'h05a;
   localparam logic [10:0] ANG_THREE_Q = 11'h10e;
   localparam logic [10:0] ANG_FULL = 11'h168;
   localparam logic [10:0] ANG_TWO_FULL = 11'h2d0;
   localparam logic [10:0] ANG_INV_BIAS = 11'h21c;

   // ********************************************
   // Timing: delay settings count in 1 ms ticks
   // ********************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // ********************************************
   // AXI responses
   // ********************************************
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ********************************************
   // Types
   // ********************************************
   typedef enum logic [1:0] {DIR_NONE, DIR_FWD, DIR_REV, DIR_SPARE} dir_mode_t;

   typedef struct packed {
      logic vt_block_opt;
      dir_mode_t dir_mode;
      logic enable;
   } stage_cfg_t;

   typedef struct packed {
      logic [MAG_W-1:0] i2_mag;
      logic [MAG_W-1:0] v2_mag;
      logic [ANG_W-1:0] i2_v2_angle;
   } meas_t;

endpackage

/* File: nps_oc_stages_monitor.sv */
// Concurrent checks on the stage outputs and the register bus answers
`timescale 1ns/1ns

module nps_oc_stages_monitor #(
   parameter int STAGES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Protection inputs
   input nps_oc_pkg::meas_t meas,
   input wire logic all_stage_inhibit,
   input wire logic [STAGES-1:0] stage_timer_block,
   // Protection outputs
   input logic [STAGES-1:0] stage_start_out,
   input logic [STAGES-1:0] stage_trip_out,
   input logic any_start_out,
   input logic ar_block_out,
   // Bus answers
   input logic s_bvalid,
   input wire logic s_bready,
   input logic [1:0] s_bresp,
   input logic s_rvalid,
   input wire logic s_rready,
   input logic [31:0] s_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // ****************************************
   // Sequences
   // ****************************************
   sequence s_inhibit_held;
      all_stage_inhibit [*2];
   endsequence

   sequence s_quiet;
      stage_start_out == '0 && stage_trip_out == '0;
   endsequence

   // ****************************************
   // Assertions
   // ****************************************
   a_any_start_or: assert property (any_start_out == |stage_start_out)
      else $error("any start differs from the stage starts");
   a_ar_block_or: assert property (ar_block_out == |stage_trip_out)
      else $error("reclose block differs from the stage trips");
   a_inhibit_quiet: assert property (s_inhibit_held |=> s_quiet)
      else $error("stage active while inhibited");
   a_trip_with_start: assert property ((stage_trip_out & ~stage_start_out) == '0)
      else $error("trip without start");
   a_block_no_trip: assert property (stage_timer_block != '0 |=>
      (stage_trip_out & $past(stage_timer_block)) == '0)
      else $error("trip through a blocked timer");
   a_low_i2_quiet: assert property (meas.i2_mag == 16'h0000 |=> stage_start_out == '0)
      else $error("start with no current");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_b |=> s_quiet ##0 (!any_start_out && !ar_block_out))
      else $error("outputs active after reset");
   a_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write answer dropped early");
   a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read answer dropped early");
endmodule

bind nps_oc_stages nps_oc_stages_monitor #(.STAGES(STAGES)) mon_u (
   .clk(clk), .rst_b(rst_b), .meas(meas), .all_stage_inhibit(all_stage_inhibit),
   .stage_timer_block(stage_timer_block), .stage_start_out(stage_start_out),
   .stage_trip_out(stage_trip_out), .any_start_out(any_start_out),
   .ar_block_out(ar_block_out), .s_bvalid(s_bvalid), .s_bready(s_bready),
   .s_bresp(s_bresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata)
);

/* File: scheme_logic_model.sv */
// Scheme logic and auto-reclose stand-in facing the stage outputs
`timescale 1ns/1ns

module scheme_logic_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Requests from the bench
   input wire logic vt_req,
   input wire logic inh_req,
   input wire logic [3:0] blk_req,
   // Mapped signals towards the stages
   output logic vt_supervision = 1'b0,
   output logic all_stage_inhibit = 1'b0,
   output logic [3:0] stage_timer_block = 4'h0,
   // Reclose side
   input wire logic ar_block_out,
   output logic rc_blocked = 1'b0
);
   // ****************************************
   // Mapped signal drive and reclose latch
   // ****************************************
   always @(posedge clk) begin
      vt_supervision <= vt_req;
      all_stage_inhibit <= inh_req;
      stage_timer_block <= blk_req;
      if (!rst_b) begin
         rc_blocked <= 1'b0;
      end else if (ar_block_out) begin
         rc_blocked <= 1'b1;
      end
   end
endmodule

/* File: nps_oc_stages_tb.sv */
// Self-checking bench for the negative sequence overcurrent stages
`timescale 1ns/1ns

module nps_oc_stages_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   nps_oc_pkg::meas_t meas = '{16'h0000, 16'h0000, 9'h05a};
   logic vt_req = 1'b0;
   logic inh_req = 1'b0;
   logic [3:0] blk_req = 4'h0;
   logic vt_sup, inh, any_start, ar_block, rc_blocked;
   logic [3:0] blk, starts, trips;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic s_arvalid = 1'b0, s_rready = 1'b0;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;

   initial begin
      forever #5 clk = ~clk;
   end

   scheme_logic_model scheme_u (.clk(clk), .rst_b(rst_b), .vt_req(vt_req),
      .inh_req(inh_req), .blk_req(blk_req), .vt_supervision(vt_sup),
      .all_stage_inhibit(inh), .stage_timer_block(blk), .ar_block_out(ar_block),
      .rc_blocked(rc_blocked));

   nps_oc_stages #(.TICK_CYCLES(10), .STAGES(4)) dut_u (.clk(clk), .rst_b(rst_b),
      .meas(meas), .vt_supervision(vt_sup), .all_stage_inhibit(inh),
      .stage_timer_block(blk), .stage_start_out(starts), .stage_trip_out(trips),
      .any_start_out(any_start), .ar_block_out(ar_block), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_awaddr(s_awaddr), .s_awprot(3'h0),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(4'hf),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
      .s_arprot(3'h0), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
      .s_rresp(s_rresp));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      s_awvalid <= 1'b1;
      s_awaddr <= a;
      s_wvalid <= 1'b1;
      s_wdata <= v;
      s_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid && s_bready) begin
            r = s_bresp;
            s_bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      s_arvalid <= 1'b1;
      s_araddr <= a;
      s_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid && s_rready) begin
            v = s_rdata;
            r = s_rresp;
            s_rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic drv(input logic [15:0] i, input logic [15:0] v, input logic [8:0] g);
      @(posedge clk);
      meas <= '{i, v, g};
      tick(3);
   endtask

   task automatic see(input logic [3:0] es, input logic [3:0] et);
      chk({22'h0, any_start, ar_block, trips, starts}, {22'h0, |es, |et, et, es});
   endtask

   // ****************************************
   // Tests
   // ****************************************
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         results();
      end
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int n;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         rd(8'(i * 4), d, r);
         chk(d, (i >= 4 && i < 8) ? 32'h0000ffff : 32'h0);
      end
      rd(8'h30, d, r);
      chk({30'h0, r}, {30'h0, nps_oc_pkg::RESP_SLVERR});
      wr(8'h00, 32'h5b11, r);
      wr(8'h04, 32'h32, r);
      for (int i = 0; i < 4; i++) wr(8'(16 + 4 * i), 32'h64, r);
      wr(8'h24, 32'h3, r);
      wr(8'h0c, 32'hffff, r);
      chk({30'h0, r}, {30'h0, nps_oc_pkg::RESP_OKAY});
      wr(8'h30, 32'h1, r);
      chk({30'h0, r}, {30'h0, nps_oc_pkg::RESP_SLVERR});
      rd(8'h24, d, r);
      chk(d, 32'h3);
      $display("register test finished");
      drv(16'h64, 16'h3c, 9'h0b4);
      see(4'h0, 4'h0);
      drv(16'h65, 16'h3c, 9'h0b4);
      see(4'h7, 4'h5);
      n = 0;
      while (!trips[1] && n < 60) begin
         tick(1);
         n++;
      end
      chk(32'(n >= 28 && n <= 38), 32'h1);
      rd(8'h0c, d, r);
      chk(d, 32'h577);
      chk({31'h0, rc_blocked}, 32'h1);
      $display("start and delay test finished");
      drv(16'h65, 16'h3c, 9'h000);
      see(4'hb, 4'hb);
      drv(16'h65, 16'h32, 9'h000);
      see(4'h3, 4'h3);
      @(posedge clk);
      vt_req <= 1'b1;
      drv(16'h65, 16'h3c, 9'h0b4);
      see(4'hb, 4'hb);
      @(posedge clk);
      vt_req <= 1'b0;
      inh_req <= 1'b1;
      tick(3);
      see(4'h0, 4'h0);
      $display("direction test finished");
      @(posedge clk);
      inh_req <= 1'b0;
      blk_req <= 4'h2;
      tick(3);
      see(4'h7, 4'h5);
      tick(50);
      see(4'h7, 4'h5);
      @(posedge clk);
      blk_req <= 4'h0;
      tick(3);
      see(4'h7, 4'h7);
      $display("timer block test finished");
      wr(8'h00, 32'h7b11, r);
      drv(16'h65, 16'h0000, 9'h0b4);
      see(4'hb, 4'hb);
      wr(8'h00, 32'h0, r);
      tick(3);
      see(4'h0, 4'h0);
      $display("mode test finished");
      results();
   end
endmodule
